/* hdl/flash_timer_pkg.sv */
// Package with register map, field layout, reset values and timing constants of the flash timer.
`default_nettype none

package flash_timer_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [11:0] CTRL_ADDR     = 12'h000;
	localparam logic [11:0] ON_TIME_ADDR  = 12'h004;
	localparam logic [11:0] OFF_TIME_ADDR = 12'h008;
	localparam logic [11:0] PULSES_ADDR   = 12'h00c;
	localparam logic [11:0] STATUS_ADDR   = 12'h010;

	// Control register field positions.
	localparam int TRIG_LSB    = 0;  // Two bits: trigger value selection.
	localparam int AFTER_LSB   = 2;  // Two bits: contact state after flashing.
	localparam int RECOV_LSB   = 4;  // Two bits: disable state after bus recovery.
	localparam int NC_BIT      = 6;  // Output wired as normally closed contact.
	localparam int SWREC_LSB   = 7;  // Two bits: switch object reaction on bus recovery.
	localparam int CTRL_WIDTH  = 9;

	// Status register field positions.
	localparam int ST_RELAY_BIT = 0;
	localparam int ST_FLASH_BIT = 1;
	localparam int ST_DIS_BIT   = 2;
	localparam int ST_SAVED_BIT = 3;
	localparam int ST_CNT_LSB   = 8;

	// Trigger value selection codes.
	localparam logic [1:0] TRIG_ON   = 2'h0;
	localparam logic [1:0] TRIG_OFF  = 2'h1;
	localparam logic [1:0] TRIG_BOTH = 2'h2;

	// Contact state after flashing.
	localparam logic [1:0] AFTER_ON      = 2'h0;
	localparam logic [1:0] AFTER_OFF     = 2'h1;
	localparam logic [1:0] AFTER_RESTORE = 2'h2;

	// Disable object value after bus recovery.
	localparam logic [1:0] RECOV_KEEP    = 2'h0;
	localparam logic [1:0] RECOV_DISABLE = 2'h1;
	localparam logic [1:0] RECOV_ENABLE  = 2'h2;

	// Switch object reaction on bus recovery.
	localparam logic [1:0] SWREC_NONE = 2'h0;
	localparam logic [1:0] SWREC_ON   = 2'h1;
	localparam logic [1:0] SWREC_OFF  = 2'h2;

	// Reset values of the writable registers.
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 9'h028;
	localparam logic [15:0] DUR_RESET    = 16'h000a;
	localparam logic [6:0]  PULSES_RESET = 7'h05;

	// Legal ranges of durations and pulse counts.
	localparam logic [15:0] DUR_MIN    = 16'h0005;
	localparam logic [6:0]  PULSES_MIN = 7'h01;
	localparam logic [6:0]  PULSES_MAX = 7'h64;

	// Timebase: one unit is 0.1 s, the clock period is 40 ns.
	localparam int CLK_PERIOD_NS = 40;
	localparam int UNIT_TIME_NS  = 100_000_000;
	localparam int UNIT_CYCLES   = UNIT_TIME_NS / CLK_PERIOD_NS;

	// Flash sequencer states, Gray coded along idle, on phase, off phase.
	typedef enum logic [1:0] {
		FL_IDLE = 2'b00,
		FL_ON   = 2'b01,
		FL_OFF  = 2'b11
	} flash_state_t;

endpackage : flash_timer_pkg

`default_nettype wire

/* hdl/unit_tick.sv */
// Restartable 0.1 s timebase that pulses once per unit.
`timescale 1ns/100ps
`default_nettype none

module unit_tick #(
	parameter int TICK_CYCLES = flash_timer_pkg::UNIT_CYCLES
) (
	input  wire logic pclk,     // System clock.
	input  wire logic presetn,  // Asynchronous reset, active low.
	input  wire logic restart,  // Start a fresh unit from zero.
	output logic      tick      // One-cycle pulse at the end of each unit.
);

	logic [31:0] count;  // Cycles elapsed in the current unit.

	// Counting restarts on request so the first phase of a flash lasts whole units.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= 32'h0;
			tick  <= 1'b0;
		end
		else if (restart)
		begin
			count <= 32'h0;
			tick  <= 1'b0;
		end
		else if (count == 32'(TICK_CYCLES - 1))
		begin
			count <= 32'h0;
			tick  <= 1'b1;
		end
		else
		begin
			count <= count + 32'h1;
			tick  <= 1'b0;
		end
	end

endmodule : unit_tick

`default_nettype wire

/* hdl/relay_output_flash_timer.sv */
// Flashing time function of one relay output with an APB register slave.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - OFF phase lasts configured 0.1 s units.
// - Stop flashing after configured pulse maximum.
// - After-flash ON leaves relay on.
// - After-flash OFF leaves relay off.
// - After-flash restore returns pre-flash state.
// - Recovery unchanged keeps prior disable state.
// - Disable telegram 1 blocks time function.
// - Disable telegram 0 enables time function.
// - While blocked, switch telegrams drive relay directly.
// - Bus recovery sets light per switch setting.
// - Same engine serves outputs S, T, U.
// - ON phase lasts configured 0.1 s units.
// - Trigger value starts, opposite value ends flashing.
// - Every new trigger value restarts sequence.
// - Normally open starts ON, closed starts OFF.
module relay_output_flash_timer #(
	parameter int TICK_CYCLES = flash_timer_pkg::UNIT_CYCLES  // Cycles per 0.1 s unit.
) (
	input  wire logic        pclk,          // System clock, 25 MHz.
	input  wire logic        presetn,       // Asynchronous reset, active low.
	input  wire logic        psel,          // APB select.
	input  wire logic        penable,       // APB access phase.
	input  wire logic        pwrite,        // APB write direction.
	input  wire logic [11:0] paddr,         // APB byte address.
	input  wire logic [31:0] pwdata,        // APB write data.
	output logic      [31:0] prdata,        // APB read data.
	output logic             pready,        // APB ready.
	output logic             pslverr,       // APB error for unmapped addresses.
	input  wire logic        switch_stb,    // Switch telegram received, one cycle.
	input  wire logic        switch_val,    // Value of the switch telegram.
	input  wire logic        disable_stb,   // Disable-time telegram received, one cycle.
	input  wire logic        disable_val,   // Value of the disable-time telegram.
	input  wire logic        bus_recovered, // Bus voltage recovery event, one cycle.
	output logic             relay_on,      // Relay coil drive, high closes the contact.
	output logic             flashing       // High while a flash sequence runs.
);

	logic [flash_timer_pkg::CTRL_WIDTH-1:0] ctrl;      // Control register.
	logic [15:0]                            on_time;   // ON phase length in units.
	logic [15:0]                            off_time;  // OFF phase length in units.
	logic [6:0]                             pulses;    // Pulse limit as written.
	logic                                   time_dis;  // Time function blocked.
	logic                                   saved;     // Switch state before flashing.
	logic                                   state_out; // Logical switch state.
	logic [6:0]                             pulse_cnt; // Completed ON phases.
	logic [15:0]                            phase_cnt; // Units spent in current phase.
	flash_timer_pkg::flash_state_t          state;     // Sequencer state.
	logic                                   tick;      // 0.1 s unit pulse.
	logic                                   restart;   // Timebase restart request.

	// Decoded control fields.
	logic [1:0] trig_sel;
	logic [1:0] after_sel;
	logic [1:0] recov_sel;
	logic       nc_contact;
	logic [1:0] swrec_sel;
	assign trig_sel   = ctrl[flash_timer_pkg::TRIG_LSB +: 2];
	assign after_sel  = ctrl[flash_timer_pkg::AFTER_LSB +: 2];
	assign recov_sel  = ctrl[flash_timer_pkg::RECOV_LSB +: 2];
	assign nc_contact = ctrl[flash_timer_pkg::NC_BIT];
	assign swrec_sel  = ctrl[flash_timer_pkg::SWREC_LSB +: 2];

	// Out-of-range settings are clamped so a bad write cannot stall or hammer the contact.
	logic [15:0] on_len;
	logic [15:0] off_len;
	logic [6:0]  pulse_max;
	assign on_len    = (on_time < flash_timer_pkg::DUR_MIN) ? flash_timer_pkg::DUR_MIN : on_time;
	assign off_len   = (off_time < flash_timer_pkg::DUR_MIN) ? flash_timer_pkg::DUR_MIN : off_time;
	assign pulse_max = (pulses < flash_timer_pkg::PULSES_MIN) ? flash_timer_pkg::PULSES_MIN :
		(pulses > flash_timer_pkg::PULSES_MAX) ? flash_timer_pkg::PULSES_MAX : pulses;

	// APB strobes; the slave never inserts wait states.
	logic wr_en;
	logic setup;
	logic mapped;
	assign pready = 1'b1;
	assign wr_en  = psel && penable && pwrite;
	assign setup  = psel && !penable;
	assign mapped = (paddr == flash_timer_pkg::CTRL_ADDR) || (paddr == flash_timer_pkg::ON_TIME_ADDR)
		|| (paddr == flash_timer_pkg::OFF_TIME_ADDR) || (paddr == flash_timer_pkg::PULSES_ADDR)
		|| (paddr == flash_timer_pkg::STATUS_ADDR);

	// Switch telegram classification while the time function is live.
	logic start_req;
	logic stop_req;
	always_comb
	begin
		start_req = 1'b0;
		stop_req  = 1'b0;
		if (switch_stb && !time_dis && !bus_recovered)
		begin
			unique case (trig_sel)
				flash_timer_pkg::TRIG_ON:
				begin
					start_req = switch_val;
					stop_req  = !switch_val;
				end
				flash_timer_pkg::TRIG_OFF:
				begin
					start_req = !switch_val;
					stop_req  = switch_val;
				end
				default:
				begin
					start_req = 1'b1;  // Either value triggers and cannot suspend.
				end
			endcase
		end
	end

	// Post-flash contact state chosen by the after-flash setting.
	logic after_val;
	always_comb
	begin
		unique case (after_sel)
			flash_timer_pkg::AFTER_ON:  after_val = 1'b1;
			flash_timer_pkg::AFTER_OFF: after_val = 1'b0;
			default:                    after_val = saved;
		endcase
	end

	// End of the current phase, reached on the tick that completes its length.
	logic on_done;
	logic off_done;
	logic last_pulse;
	assign on_done    = (state == flash_timer_pkg::FL_ON) && tick && (phase_cnt + 16'h1 >= on_len);
	assign off_done   = (state == flash_timer_pkg::FL_OFF) && tick && (phase_cnt + 16'h1 >= off_len);
	assign last_pulse = on_done && (pulse_cnt + 7'h1 >= pulse_max);

	// A flash is abandoned by a stop telegram, by blocking or by bus recovery.
	logic abort;
	assign abort = stop_req || (disable_stb && disable_val) || bus_recovered;

	// Timebase restarts at every flash start so the first phase is full length.
	assign restart = start_req;

	unit_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.restart (restart),
		.tick    (tick)
	);

	// Software-written registers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl     <= flash_timer_pkg::CTRL_RESET;
			on_time  <= flash_timer_pkg::DUR_RESET;
			off_time <= flash_timer_pkg::DUR_RESET;
			pulses   <= flash_timer_pkg::PULSES_RESET;
		end
		else if (wr_en)
		begin
			// Writes land only at the access phase of the transfer.
			unique case (paddr)
				flash_timer_pkg::CTRL_ADDR:     ctrl     <= pwdata[flash_timer_pkg::CTRL_WIDTH-1:0];
				flash_timer_pkg::ON_TIME_ADDR:  on_time  <= pwdata[15:0];
				flash_timer_pkg::OFF_TIME_ADDR: off_time <= pwdata[15:0];
				flash_timer_pkg::PULSES_ADDR:   pulses   <= pwdata[6:0];
				default:
				begin
					// Status is read only and unmapped writes are dropped.
				end
			endcase
		end
	end

	// Read data and error are prepared in the setup cycle so they come from flip-flops.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			pslverr <= !mapped;
			prdata  <= 32'h0;
			if (!pwrite)
			begin
				unique case (paddr)
					flash_timer_pkg::CTRL_ADDR:     prdata <= 32'(ctrl);
					flash_timer_pkg::ON_TIME_ADDR:  prdata <= 32'(on_time);
					flash_timer_pkg::OFF_TIME_ADDR: prdata <= 32'(off_time);
					flash_timer_pkg::PULSES_ADDR:   prdata <= 32'(pulses);
					flash_timer_pkg::STATUS_ADDR:
					begin
						prdata[flash_timer_pkg::ST_RELAY_BIT] <= relay_on;
						prdata[flash_timer_pkg::ST_FLASH_BIT] <= flashing;
						prdata[flash_timer_pkg::ST_DIS_BIT]   <= time_dis;
						prdata[flash_timer_pkg::ST_SAVED_BIT] <= saved;
						prdata[flash_timer_pkg::ST_CNT_LSB +: 7] <= pulse_cnt;
					end
					default:
					begin
						// Unmapped reads return zero with an error.
					end
				endcase
			end
		end
		else if (!psel)
		begin
			pslverr <= 1'b0;
		end
	end

	// Blocked condition of the time function; a recovery preset wins over a telegram.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			time_dis <= 1'b0;
		end
		else if (bus_recovered)
		begin
			unique case (recov_sel)
				flash_timer_pkg::RECOV_DISABLE: time_dis <= 1'b1;
				flash_timer_pkg::RECOV_ENABLE:  time_dis <= 1'b0;
				default:                        time_dis <= time_dis;
			endcase
		end
		else if (disable_stb)
		begin
			time_dis <= disable_val;
		end
	end

	// Flash sequencer; the first phase depends on the contact type.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state     <= flash_timer_pkg::FL_IDLE;
			phase_cnt <= 16'h0;
			pulse_cnt <= 7'h0;
		end
		else if (abort)
		begin
			state     <= flash_timer_pkg::FL_IDLE;
			phase_cnt <= 16'h0;
		end
		else if (start_req)
		begin
			// Any new trigger value restarts from the first phase and a zero pulse count.
			state     <= nc_contact ? flash_timer_pkg::FL_OFF : flash_timer_pkg::FL_ON;
			phase_cnt <= 16'h0;
			pulse_cnt <= 7'h0;
		end
		else
		begin
			unique case (state)
				flash_timer_pkg::FL_IDLE:
				begin
					phase_cnt <= 16'h0;
				end
				flash_timer_pkg::FL_ON:
				begin
					if (last_pulse)
					begin
						state     <= flash_timer_pkg::FL_IDLE;
						pulse_cnt <= pulse_cnt + 7'h1;
						phase_cnt <= 16'h0;
					end
					else if (on_done)
					begin
						state     <= flash_timer_pkg::FL_OFF;
						pulse_cnt <= pulse_cnt + 7'h1;
						phase_cnt <= 16'h0;
					end
					else if (tick)
					begin
						phase_cnt <= phase_cnt + 16'h1;
					end
				end
				flash_timer_pkg::FL_OFF:
				begin
					if (off_done)
					begin
						state     <= flash_timer_pkg::FL_ON;
						phase_cnt <= 16'h0;
					end
					else if (tick)
					begin
						phase_cnt <= phase_cnt + 16'h1;
					end
				end
				default:
				begin
					state <= flash_timer_pkg::FL_IDLE;
				end
			endcase
		end
	end

	// The pre-flash state is captured only at a fresh start, not at a restart.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			saved <= 1'b0;
		end
		else if (start_req && (state == flash_timer_pkg::FL_IDLE))
		begin
			saved <= state_out;
		end
	end

	// Steady switch state outside flashing, in the relay's own sense.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_out <= 1'b0;
		end
		else if (bus_recovered)
		begin
			unique case (swrec_sel)
				flash_timer_pkg::SWREC_ON:  state_out <= 1'b1;
				flash_timer_pkg::SWREC_OFF: state_out <= 1'b0;
				default:                    state_out <= relay_on;
			endcase
		end
		else if (switch_stb && time_dis)
		begin
			state_out <= switch_val;
		end
		else if (stop_req || last_pulse)
		begin
			state_out <= after_val;
		end
		else if (disable_stb && disable_val && flashing)
		begin
			// Blocking mid-flash freezes the contact where it stands.
			state_out <= relay_on;
		end
	end

	// Relay drive follows the phase during a flash and the steady state otherwise.
	// The same logic is instantiated per output, including the small outputs.
	always_comb
	begin
		unique case (state)
			flash_timer_pkg::FL_ON:  relay_on = 1'b1;
			flash_timer_pkg::FL_OFF: relay_on = 1'b0;
			default:                 relay_on = state_out;
		endcase
	end

	assign flashing = (state != flash_timer_pkg::FL_IDLE);

endmodule : relay_output_flash_timer

`default_nettype wire

/* test/flash_timer_sva.sv */
// Concurrent checks on the flash timer ports.
`timescale 1ns/100ps
`default_nettype none
module flash_timer_chk #(
	parameter int TICK_CYCLES = 4  // Cycles per 0.1 s unit.
) (
	input wire logic        pclk,          // Clock.
	input wire logic        presetn,       // Reset, active low.
	input wire logic        psel,          // APB select.
	input wire logic        penable,       // APB access phase.
	input wire logic        pwrite,        // APB direction.
	input wire logic [11:0] paddr,         // APB address.
	input wire logic [31:0] prdata,        // APB read data.
	input wire logic        pready,        // APB ready.
	input wire logic        pslverr,       // APB error.
	input wire logic        switch_stb,    // Switch telegram.
	input wire logic        disable_stb,   // Disable telegram.
	input wire logic        disable_val,   // Disable value.
	input wire logic        bus_recovered, // Recovery event.
	input wire logic        relay_on,      // Relay drive.
	input wire logic        flashing       // Sequence running.
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic        last_relay; // Relay level one cycle earlier.
	logic [15:0] run;        // Cycles the relay level has stood.
	// Saturate the count so long idle spans never wrap into a short phase.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			last_relay <= 1'b0;
			run        <= 16'h0000;
		end
		else
		begin
			last_relay <= relay_on;
			run        <= (relay_on != last_relay) ? 16'h0000 : run + {15'h0000, ~&run};
		end
	end
	a_pready_high: assert property (pready) else $error("pready low");
	a_unmapped_err: assert property (psel && !penable && paddr > 12'h010 |=> pslverr)
		else $error("unmapped access without error");
	a_mapped_ok: assert property (psel && !penable && paddr <= 12'h010 && paddr[1:0] == 2'h0
		|=> !pslverr) else $error("error on mapped access");
	a_write_zero: assert property (psel && !penable && pwrite |=> prdata == 32'h00000000)
		else $error("read data not zero on write");
	a_disable_stop: assert property (disable_stb && disable_val |=> !flashing)
		else $error("flashing after disable");
	a_recover_stop: assert property (bus_recovered |=> !flashing)
		else $error("flashing after recovery");
	a_relay_cause: assert property (!flashing && !$past(flashing) && !$past(switch_stb)
		&& !$past(bus_recovered) |-> relay_on == last_relay) else $error("relay moved alone");
	a_phase_min: assert property (flashing && $past(flashing) && !$past(switch_stb)
		&& relay_on != last_relay |-> run >= 16'(5 * TICK_CYCLES - 3))
		else $error("flash phase too short");
endmodule : flash_timer_chk
bind relay_output_flash_timer flash_timer_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .switch_stb(switch_stb),
	.disable_stb(disable_stb), .disable_val(disable_val), .bus_recovered(bus_recovered),
	.relay_on(relay_on), .flashing(flashing));
`default_nettype wire

/* test/telegram_bus.sv */
// Building bus model that delivers switch, disable and recovery telegrams.
`timescale 1ns/100ps
`default_nettype none
module telegram_bus (
	input  wire logic pclk,          // Clock.
	output var logic  switch_stb,    // Switch telegram strobe.
	output var logic  switch_val,    // Switch telegram value.
	output var logic  disable_stb,   // Disable telegram strobe.
	output var logic  disable_val,   // Disable telegram value.
	output var logic  bus_recovered  // Recovery event.
);
	// The bus is quiet until the first telegram.
	initial
	begin
		switch_stb    = 1'b0;
		switch_val    = 1'b0;
		disable_stb   = 1'b0;
		disable_val   = 1'b0;
		bus_recovered = 1'b0;
	end
	// One telegram is a one-cycle strobe; kind 0 switch, 1 disable, 2 recovery.
	// Idle value lines show the inverse, so a stale value is never mistaken for a fresh one.
	task automatic send(input logic [1:0] kind, input logic v);
		@(posedge pclk);
		switch_stb    <= (kind == 2'h0);
		disable_stb   <= (kind == 2'h1);
		bus_recovered <= (kind == 2'h2);
		switch_val    <= v;
		disable_val   <= v;
		@(posedge pclk);
		switch_stb    <= 1'b0;
		disable_stb   <= 1'b0;
		bus_recovered <= 1'b0;
		switch_val    <= ~v;
		disable_val   <= ~v;
	endtask : send
endmodule : telegram_bus
`default_nettype wire

/* test/relay_output_flash_timer_tb.sv */
// Self-checking bench of the flash timer.
`timescale 1ns/100ps
`default_nettype none
module relay_output_flash_timer_tb;
	localparam int T = 4; // Short unit keeps each phase at tens of cycles.
	typedef struct packed {logic [31:0] m; logic [31:0] v;} note_t;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr; // APB side.
	logic        sw_stb, sw_val, dis_stb, dis_val, recov, relay_on, flashing; // Telegrams.
	logic [11:0] paddr;             // Address.
	logic [31:0] pwdata, prdata, w; // Data words.
	note_t       q[$], nt;          // Expected reads, oldest first.
	int          error_cnt, compares, cyc, t0, seed; // Counters.
	logic [8:0]  row_c[3] = '{9'h004, 9'h002, 9'h048}; // Flash run settings.
	logic [8:0]  rec_c[3] = '{9'h084, 9'h124, 9'h014}; // Recovery settings.
	logic [2:0]  rec_e[3] = '{3'h5, 3'h0, 3'h4};       // Disabled, flashing, relay.
	logic [2:0]  sv = 3'h5, fst = 3'h3, fin = 3'h6;    // Start value, first, final level.
	relay_output_flash_timer #(.TICK_CYCLES(T)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .switch_stb(sw_stb),
		.switch_val(sw_val), .disable_stb(dis_stb), .disable_val(dis_val),
		.bus_recovered(recov), .relay_on(relay_on), .flashing(flashing));
	telegram_bus BUS (.pclk(pclk), .switch_stb(sw_stb), .switch_val(sw_val),
		.disable_stb(dis_stb), .disable_val(dis_val), .bus_recovered(recov));
	// Free running clock and a cycle count for the timeline.
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: read %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	task automatic hang();
		error_cnt++;
		$display("mismatch at %0t: wait ran out", $time);
		stop_test();
	endtask : hang
	// One APB transfer; the request stands until pready is seen at an edge.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge pclk);
		end
		if (pready !== 1'b1)
			hang();
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		q.push_back('{m, e});
		apb(1'b0, a, 32'h00000000);
	endtask : rd
	task automatic tele(input logic [1:0] k, input logic v);
		BUS.send(k, v);
		t0 = cyc;
	endtask : tele
	task automatic wait_to(input int n);
		while (cyc < t0 + n)
			@(posedge pclk);
	endtask : wait_to
	// Each completed read is compared against the oldest expectation.
	always @(posedge pclk)
	begin
		if (psel && penable && pready && !pwrite)
		begin
			nt = q.pop_front();
			check(prdata & nt.m, nt.v);
			// Of the word-aligned addresses, only those past the status register lie outside the map.
			check({31'h0, pslverr}, {31'h0, paddr > flash_timer_pkg::STATUS_ADDR});
		end
	end
	// Watchdog against a stuck sequence.
	initial
	begin
		repeat (20000) @(posedge pclk);
		hang();
	end
	initial
	begin
		{seed, error_cnt, compares, cyc, t0} = {32'd86, 128'h0};
		{presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h000, 32'hffffffff, 32'h00000028);
		rd(12'h004, 32'hffffffff, 32'h0000000a);
		rd(12'h008, 32'hffffffff, 32'h0000000a);
		rd(12'h00c, 32'hffffffff, 32'h00000005);
		rd(12'h010, 32'h00000003, 32'h00000000);
		rd(12'h014, 32'hffffffff, 32'h00000000);
		apb(1'b1, 12'h020, $random(seed));
		w = 32'h00000005 + ({$random(seed)} & 32'h00007fff);
		apb(1'b1, 12'h004, w);
		rd(12'h004, 32'hffffffff, w);
		apb(1'b1, 12'h010, $random(seed));
		rd(12'h010, 32'h00000003, 32'h00000000);
		apb(1'b1, 12'h004, 32'h00000005);
		apb(1'b1, 12'h008, 32'h00000006);
		apb(1'b1, 12'h00c, 32'h00000002);
		tele(2'h1, 1'b0);
		// ON phase 20 cycles, OFF phase 24, two pulses end by cycle 66, or by cycle 90 with the normally closed contact.
		for (int r = 0; r < 3; r++)
		begin
			apb(1'b1, 12'h000, {23'h0, row_c[r]});
			tele(2'h0, sv[r]);
			wait_to(10);
			rd(12'h010, 32'h00000003, {30'h0, 1'b1, fst[r]});
			wait_to(32);
			rd(12'h010, 32'h00000003, {30'h0, 1'b1, ~fst[r]});
			wait_to(90);
			rd(12'h010, 32'h00007f03, {30'h0, 1'b0, fin[r]} | 32'h00000200);
		end
		// A second start in the OFF phase must restart the sequence from the ON phase, still flashing 54 cycles later.
		apb(1'b1, 12'h000, 32'h00000005);
		tele(2'h0, 1'b0);
		wait_to(32);
		tele(2'h0, 1'b0);
		wait_to(10);
		rd(12'h010, 32'h00000003, 32'h00000003);
		wait_to(54);
		rd(12'h010, 32'h00000003, 32'h00000003);
		tele(2'h0, 1'b1);
		rd(12'h010, 32'h00000003, 32'h00000000);
		// Blocked time function switches the relay directly.
		apb(1'b1, 12'h000, 32'h00000004);
		tele(2'h1, 1'b1);
		tele(2'h0, 1'b1);
		rd(12'h010, 32'h00000007, 32'h00000005);
		tele(2'h0, 1'b0);
		rd(12'h010, 32'h00000003, 32'h00000000);
		tele(2'h1, 1'b0);
		tele(2'h0, 1'b1);
		wait_to(10);
		rd(12'h010, 32'h00000007, 32'h00000003);
		tele(2'h1, 1'b1);
		rd(12'h010, 32'h00000007, 32'h00000005);
		for (int r = 0; r < 3; r++)
		begin
			apb(1'b1, 12'h000, {23'h0, rec_c[r]});
			tele(2'h2, 1'b0);
			rd(12'h010, 32'h00000007, {29'h0, rec_e[r]});
		end
		// Blocked by the recovery preset, a switch telegram sets the relay directly.
		tele(2'h0, 1'b1);
		rd(12'h010, 32'h00000007, 32'h00000005);
		stop_test();
	end
endmodule : relay_output_flash_timer_tb
`default_nettype wire
